// ==== testbench/mfg_board.sv ====
`timescale 1ns/100ps
`default_nettype none
module mfg_board (
	input wire logic mclk,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic pullUpEn,
	input wire logic pullDownEn,
	input wire logic drive,
	input wire logic level,
	output logic pinIn
);
	logic flt = 1'b0;
	// a floating pin with no pull keeps changing
	always @(posedge mclk) flt <= !flt;
	assign pinIn = pinOe ? pinOut : drive ? level : pullUpEn ? 1'b1 : pullDownEn ? 1'b0 : flt;
endmodule
`default_nettype wire

// ==== testbench/mfg_pin_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module mfg_pin_chk
	import mfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic irq,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic pullUpEn,
	input wire logic pullDownEn
);
	logic [15:0] c;
	logic m;
	logic [1:0] q;
	wire logic acc = write && !waitrequest;
	// no accepted write for two edges
	wire logic calm = &q;
	wire logic outEn = calm && c[B_ENA] && !c[B_DIR];
	always_ff @(posedge mclk) begin
		q <= rst ? 2'h0 : {q[0], !acc};
	end
	always_ff @(posedge mclk) begin
		if (rst)
			c <= CONTROL_RESET;
		else if (acc && address == ADDR_CONTROL)
			c <= writedata[15:0] & CONTROL_MASK;
	end
	always_ff @(posedge mclk) begin
		if (rst)
			m <= 1'b0;
		else if (acc && address == ADDR_MASK)
			m <= |writedata[IRQ_W-1:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence req_s;
		$rose(read) || $rose(write);
	endsequence
	sequence ack_s;
		waitrequest ##1 !waitrequest ##1 waitrequest;
	endsequence
	bus_ack_a: assert property (req_s |-> ack_s)
		else $error("bus answer late");
	tri_state_a: assert property (calm && !c[B_ENA] |-> !pinOe)
		else $error("pin driven while disabled");
	input_dir_a: assert property (calm && c[B_DIR] |-> !pinOe)
		else $error("pin driven as input");
	pull_up_a: assert property (calm |-> pullUpEn == (c[14:13] == PULL_UP))
		else $error("pull up wrong");
	pull_down_a: assert property (calm |-> pullDownEn == (c[14:13] == PULL_DOWN))
		else $error("pull down wrong");
	push_pull_a: assert property (outEn && !c[B_OD] |-> pinOe)
		else $error("push pull not driven");
	open_drain_a: assert property (outEn && c[B_OD] |-> !pinOut)
		else $error("open drain drives high");
	reserved_out_a: assert property (outEn && !c[B_OD] && c[B_POL] && c[3:0] inside {[5:7]}
		|-> !pinOut)
		else $error("reserved code drives high");
	irq_mask_a: assert property (calm && !m |-> !irq)
		else $error("masked interrupt seen");
	ctl_read_a: assert property (read && !waitrequest && address == ADDR_CONTROL
		|-> readdata[15:0] == c)
		else $error("control readback wrong");
	unmapped_a: assert property (read && !waitrequest && address == 16'h4000 |-> readdata == 0)
		else $error("unmapped read not zero");
endmodule
bind mfg_pin mfg_pin_chk u_chk (.*);
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import mfg_pkg::*;
	logic mclk, rst, read, write, drive, level, irq, waitrequest, pinIn, pinOut, pinOe;
	logic pullUpEn, pullDownEn, powerDomain;
	logic [15:0] address, src, rnd, ctl, inReq;
	logic [31:0] writedata, readdata, q;
	int nErrors, samplesChecked, t, d;
	mfg_pin u_dut (.mclk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.irq, .pinIn, .pinOut, .pinOe, .pullUpEn, .pullDownEn, .powerDomain, .stateOn(src[2]),
		.stateSleep(src[3]), .stateChange(src[4]), .scaleDoneOne(src[8]), .scaleDoneTwo(src[9]),
		.extPowerEnOne(src[10]), .extPowerEnTwo(src[11]), .system_supply_good(src[12]),
		.converter_power_good(src[13]), .auxReset(src[15]), .inputRequest(inReq));
	mfg_board u_board (.mclk, .pinOut, .pinOe, .pullUpEn, .pullDownEn, .drive, .level, .pinIn);
	function logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task stopTest;
		$display("mismatches %0d checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] s, input string n);
		samplesChecked++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			nErrors++;
		end
	endtask
	task bus(input logic w, input logic [15:0] a, input logic [31:0] dt);
		int i;
		@(posedge mclk);
		address <= a;
		writedata <= dt;
		read <= !w;
		write <= w;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (waitrequest !== 1'b0 && i < 40);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 40) begin
			$display("mismatch bus answer expected %h seen %h", 1'b0, waitrequest);
			nErrors++;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		wt(80000);
		nErrors++;
		stopTest;
	end
	initial begin
		{nErrors, samplesChecked} = 0;
		{rst, read, write, level, drive} = 5'h11;
		{address, src, writedata} = '0;
		rnd = 16'h0021;
		wt(16);
		rst <= 1'b0;
		bus(0, ADDR_CONTROL, 0);
		chk(CONTROL_RESET, q, "control reset");
		chk(1, pullDownEn, "pull down reset");
		bus(1, 16'h4000, 32'h1);
		bus(0, 16'h4000, 0);
		chk(0, q, "unmapped");
		for (int p = 0; p < 3; p++) begin
			rnd = lfsr(rnd);
			ctl = {1'b1, p[1:0], rnd[12:0]} & CONTROL_MASK;
			bus(1, ADDR_CONTROL, {16'h0, ctl});
			bus(0, ADDR_CONTROL, 0);
			chk(ctl, q, "control");
			chk(p == 2, pullUpEn, "pull up");
			chk(p == 1, pullDownEn, "pull down");
			chk(ctl[B_DOMAIN], powerDomain, "power domain");
		end
		$display("test registers done");
		for (int f = 0; f < NFN; f++) begin
			rnd = lfsr(rnd);
			src <= rnd & 16'hbf1c;
			bus(1, ADDR_OUT, {31'h0, rnd[0]});
			ctl = {5'h0, rnd[5] | (f inside {[5:7]}), 3'h1, 3'h0, f[3:0]};
			bus(1, ADDR_CONTROL, {16'h0, ctl});
			wt(8);
			t = 0;
			for (int k = 0; k < 4 * (f == 1 ? SLOW_HALF : FAST_HALF); k++) begin
				@(posedge mclk);
				t += int'(pinOut != q[0]);
				q[0] = pinOut;
			end
			chk(1, pinOe, "output drive");
			if (f == 1 || f == 14)
				chk(1, t inside {[3:5]}, "clock toggles");
			else
				chk((f == 0 ? rnd[0] : src[f]) ^ !ctl[B_POL], pinOut, "pin out");
		end
		bus(1, ADDR_OUT, 0);
		bus(1, ADDR_CONTROL, 32'h0680);
		wt(4);
		chk(1, pinOe, "open drain low");
		chk(0, pinOut, "open drain out");
		bus(1, ADDR_CONTROL, 0);
		wt(4);
		chk(0, pinOe, "tristate");
		$display("test outputs done");
		for (int f = 0; f < NFN; f++) begin
			rnd = lfsr(rnd);
			level <= !rnd[5];
			bus(1, ADDR_MASK, {31'h0, rnd[1]});
			bus(0, ADDR_MASK, 0);
			chk(rnd[1], q, "mask");
			bus(1, ADDR_CONTROL, {16'h0, 3'h5, rnd[2], 1'b0, rnd[5], 3'h1, 3'h0, f[3:0]});
			d = (f == 0 || f == 4 || f > 13) ? LONG_DEB : SHORT_DEB;
			wt(d + 40);
			bus(1, ADDR_IRQ, 32'h3);
			for (int s = 1; s >= 0; s--) begin
				level <= s[0] ^ !rnd[5];
				wt(d + 40);
				chk(s ? 1 << f : 0, inReq, "request");
				chk(rnd[1] & (s[0] | rnd[2]), irq, "irq");
				bus(0, ADDR_IRQ, 0);
				chk({s[0] & (f > 1), s[0] | rnd[2]}, q[1:0], "irq status");
				bus(1, ADDR_IRQ, 32'h3);
			end
		end
		$display("test inputs done");
		rst <= 1'b1;
		wt(16);
		rst <= 1'b0;
		bus(0, ADDR_CONTROL, 0);
		chk(CONTROL_RESET, q, "control after reset");
		chk(0, pinOe, "oe after reset");
		chk(0, irq, "irq after reset");
		$display("test reset done");
		stopTest;
	end
endmodule
`default_nettype wire

// ==== verilog/mfg_debounce.sv ====
`timescale 1ns/100ps
`default_nettype none
module mfg_debounce
	import mfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic raw,
	input wire logic longSel,
	output logic clean
);
	logic [DEB_W-1:0] count;
	logic [DEB_W-1:0] limit;
	assign limit = longSel ? DEB_W'(LONG_DEB) : DEB_W'(SHORT_DEB);

	// level must hold for the whole window before it is accepted
	always_ff @(posedge mclk) begin
		if (rst) begin
			clean <= 1'b0;
			count <= '0;
		end else if (raw == clean) begin
			count <= '0;
		end else if (count >= limit - DEB_W'(1)) begin
			clean <= raw;
			count <= '0;
		end else begin
			count <= count + DEB_W'(1);
		end
	end
endmodule
`default_nettype wire

// ==== verilog/mfg_pin.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mfg_pin
	import mfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	output logic pullUpEn,
	output logic pullDownEn,
	output logic powerDomain,
	input wire logic stateOn,
	input wire logic stateSleep,
	input wire logic stateChange,
	input wire logic scaleDoneOne,
	input wire logic scaleDoneTwo,
	input wire logic extPowerEnOne,
	input wire logic extPowerEnTwo,
	input wire logic system_supply_good,
	input wire logic converter_power_good,
	input wire logic auxReset,
	output logic [NFN-1:0] inputRequest
);
	import mfg_pkg::*;

	logic [15:0] pin4_control;
	logic outLevel;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	mfg_bus_e busState;
	logic [31:0] next_readdata;
	logic dbLevel;
	logic sense;

	logic pin_direction;
	logic [1:0] pull_select;
	logic irq_edge_mode;
	logic pin_polarity;
	logic open_drain_select;
	logic pin_enable;
	logic [3:0] pin_function_code;
	assign pin_direction = pin4_control[B_DIR];
	assign pull_select = pin4_control[B_PULL_HI:B_PULL_LO];
	assign irq_edge_mode = pin4_control[B_EDGE];
	assign pin_polarity = pin4_control[B_POL];
	assign open_drain_select = pin4_control[B_OD];
	assign pin_enable = pin4_control[B_ENA];
	assign pin_function_code = pin4_control[B_FN_HI:0];

	logic wrStrobe;
	assign wrStrobe = write && busState == BS_ACK;

	// slave answers in the second cycle of a request
	always_ff @(posedge mclk) begin
		if (rst) begin
			busState <= BS_IDLE;
			waitrequest <= 1'b1;
		end else begin
			unique case (busState)
				BS_IDLE: begin
					if (read || write) begin
						busState <= BS_ACK;
						waitrequest <= 1'b0;
					end
				end
				BS_ACK: begin
					busState <= BS_DONE;
					waitrequest <= 1'b1;
				end
				BS_DONE: begin
					busState <= BS_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		next_readdata = 32'h0;
		unique case (address)
			ADDR_CONTROL: next_readdata[15:0] = pin4_control;
			ADDR_STATUS: next_readdata[3:0] = {pinOe, pinOut, sense, dbLevel};
			ADDR_IRQ: next_readdata[IRQ_W-1:0] = irqStatus;
			ADDR_MASK: next_readdata[IRQ_W-1:0] = irqMask;
			ADDR_OUT: next_readdata[0] = outLevel;
			default: next_readdata = 32'h0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			readdata <= 32'h0;
		end else if (busState == BS_IDLE && read) begin
			readdata <= next_readdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin4_control <= CONTROL_RESET;
		end else if (wrStrobe && address == ADDR_CONTROL) begin
			pin4_control <= writedata[15:0] & CONTROL_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			outLevel <= 1'b0;
		end else if (wrStrobe && address == ADDR_OUT) begin
			outLevel <= writedata[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irqMask <= '0;
		end else if (wrStrobe && address == ADDR_MASK) begin
			irqMask <= writedata[IRQ_W-1:0];
		end
	end

	// input path: filter, then polarity
	logic longSel;
	logic senseLast;
	assign longSel = pin_function_code == FN_IN_LONG
		|| pin_function_code == FN_IN_SW_LONG
		|| pin_function_code == FN_IN_HC1_LONG
		|| pin_function_code == FN_IN_HC2_LONG;
	mfg_debounce u_deb (
		.mclk(mclk),
		.rst(rst),
		.raw(pinIn),
		.longSel(longSel),
		.clean(dbLevel)
	);
	assign sense = pin_polarity ? dbLevel : ~dbLevel;

	logic inputActive;
	assign inputActive = pin_enable && pin_direction;
	always_ff @(posedge mclk) begin
		if (rst) begin
			senseLast <= 1'b0;
		end else begin
			senseLast <= sense;
		end
	end

	logic edgeSeen;
	// single-edge mode: active-going edge of the sensed level
	assign edgeSeen = inputActive && (irq_edge_mode ? (sense != senseLast)
		: (sense && !senseLast));

	// one request line per function code
	genvar g;
	generate
		for (g = 0; g < NFN; g++) begin : gReq
			always_ff @(posedge mclk) begin
				if (rst) begin
					inputRequest[g] <= 1'b0;
				end else begin
					inputRequest[g] <= inputActive && sense
						&& pin_function_code == 4'(g);
				end
			end
		end
	endgenerate

	// plain input codes set no request interrupt bit of their own
	logic plainInput;
	logic requestRise;
	logic [IRQ_W-1:0] irqSet;
	assign plainInput = pin_function_code == FN_IN_LONG || pin_function_code == FN_IN_PLAIN;
	assign requestRise = inputActive && sense && !senseLast && !plainInput;
	assign irqSet = {requestRise, edgeSeen};

	// set wins over write-one-to-clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= irqSet | (irqStatus
				& ~((wrStrobe && address == ADDR_IRQ) ? writedata[IRQ_W-1:0] : '0));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

	// dividers give one-cycle ticks at twice each output rate
	logic [11:0] slowCnt;
	logic [5:0] fastCnt;
	logic slowTick;
	logic fastTick;
	logic slowClk;
	logic fastClk;
	assign slowTick = slowCnt == 12'(SLOW_HALF - 1);
	assign fastTick = fastCnt == 6'(FAST_HALF - 1);
	always_ff @(posedge mclk) begin
		if (rst || slowTick) begin
			slowCnt <= '0;
		end else begin
			slowCnt <= slowCnt + 12'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			slowClk <= 1'b0;
		end else if (slowTick) begin
			slowClk <= ~slowClk;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst || fastTick) begin
			fastCnt <= '0;
		end else begin
			fastCnt <= fastCnt + 6'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			fastClk <= 1'b0;
		end else if (fastTick) begin
			fastClk <= ~fastClk;
		end
	end

	logic srcLevel;
	always_comb begin
		unique case (pin_function_code)
			FN_OUT_LEVEL: srcLevel = outLevel;
			FN_OUT_SLOW: srcLevel = slowClk;
			4'h2: srcLevel = stateOn;
			4'h3: srcLevel = stateSleep;
			4'h4: srcLevel = stateChange;
			4'h8: srcLevel = scaleDoneOne;
			4'h9: srcLevel = scaleDoneTwo;
			4'ha: srcLevel = extPowerEnOne;
			4'hb: srcLevel = extPowerEnTwo;
			4'hc: srcLevel = system_supply_good;
			4'hd: srcLevel = converter_power_good;
			FN_OUT_FAST: srcLevel = fastClk;
			4'hf: srcLevel = auxReset;
			default: srcLevel = 1'b0;
		endcase
	end

	logic driveLevel;
	assign driveLevel = pin_polarity ? srcLevel : ~srcLevel;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pinOut <= 1'b0;
			pinOe <= 1'b0;
		end else if (!pin_enable || pin_direction) begin
			pinOut <= 1'b0;
			pinOe <= 1'b0;
		end else if (open_drain_select) begin
			pinOut <= 1'b0;
			pinOe <= ~driveLevel;
		end else begin
			pinOut <= driveLevel;
			pinOe <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pullUpEn <= 1'b0;
		end else begin
			pullUpEn <= pull_select == PULL_UP;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pullDownEn <= 1'b0;
		end else begin
			pullDownEn <= pull_select == PULL_DOWN;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			powerDomain <= 1'b0;
		end else begin
			powerDomain <= pin4_control[B_DOMAIN];
		end
	end
endmodule
`default_nettype wire

// ==== verilog/mfg_pkg.sv ====
// Behaviour
// - enable clear tri-states pin; bit15 selects direction
// - pull field: none, down, up; 11 reserved
// - single-edge interrupt follows polarity
// - edge mode one: both edges interrupt
// - polarity zero inverts pin sense
// - driver bit: push-pull or open drain
// - input codes 0-4: plain, power, sleep/wake
// - input codes 5-9: sleep, on, watchdog, scaling
// - input codes 10-15: hardware enables and controls
// - output codes 0-1: register level, 32k clock
// - output codes 2-4: power states; 5-7 reserved
// - output codes 8-11: scaling done, power enables
// - output codes 12-13: supply good, power good
// - output codes 14-15: 2MHz clock, auxiliary reset
package mfg_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int SLOW_HZ = 32768;
	localparam int FAST_HZ = 2000000;
	// half-period counts of the two generated clocks
	localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
	localparam int FAST_HALF = CLK_HZ / (2 * FAST_HZ);
	localparam int LONG_DEB_US = 20;
	localparam int SHORT_DEB_US = 1;
	localparam int LONG_DEB = LONG_DEB_US * (CLK_HZ / 1000000);
	localparam int SHORT_DEB = SHORT_DEB_US * (CLK_HZ / 1000000);
	localparam int DEB_W = 12;

	localparam logic [15:0] ADDR_CONTROL = 16'h403b;
	localparam logic [15:0] ADDR_STATUS = 16'h4040;
	localparam logic [15:0] ADDR_IRQ = 16'h4041;
	localparam logic [15:0] ADDR_MASK = 16'h4042;
	localparam logic [15:0] ADDR_OUT = 16'h4043;

	localparam int B_DIR = 15;
	localparam int B_PULL_HI = 14;
	localparam int B_PULL_LO = 13;
	localparam int B_EDGE = 12;
	localparam int B_DOMAIN = 11;
	localparam int B_POL = 10;
	localparam int B_OD = 9;
	localparam int B_ENA = 7;
	localparam int B_FN_HI = 3;
	// writable bits of the control word
	localparam logic [15:0] CONTROL_MASK = 16'hfe8f;
	localparam logic [15:0] CONTROL_RESET = 16'ha400;

	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;

	localparam int NFN = 16;
	localparam logic [3:0] FN_IN_LONG = 4'h0;
	localparam logic [3:0] FN_IN_PLAIN = 4'h1;
	localparam logic [3:0] FN_IN_SW_LONG = 4'h4;
	localparam logic [3:0] FN_IN_HC1_LONG = 4'he;
	localparam logic [3:0] FN_IN_HC2_LONG = 4'hf;
	localparam logic [3:0] FN_OUT_LEVEL = 4'h0;
	localparam logic [3:0] FN_OUT_SLOW = 4'h1;
	localparam logic [3:0] FN_OUT_FAST = 4'he;

	// interrupt status bits
	localparam int IRQ_EDGE = 0;
	localparam int IRQ_REQ = 1;
	localparam int IRQ_W = 2;

	typedef enum logic [2:0] {
		BS_IDLE = 3'b001,
		BS_ACK = 3'b010,
		BS_DONE = 3'b100
	} mfg_bus_e;
endpackage
